// ---- hw/pwrcfg_fbdiv.sv ----
`timescale 1ns/1ps
module pwrcfg_fbdiv (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       hold,
   input  wire logic [1:0] first_sel,
   input  wire logic [1:0] second_sel,
   output logic            first_tick,
   output logic            sample_tick
);
   import pwrcfg_pkg::*;

   logic [2:0] first_count;
   logic [1:0] second_count;
   logic [2:0] first_last;
   logic [1:0] second_last;
   wire        first_wrap  = (first_count == first_last);
   wire        second_wrap = (second_count == second_last);

   // first stage: /5 /4 /3, reserved code runs as /5
   assign first_last  = (first_sel == 2'h1) ? 3'h3 : (first_sel == 2'h2) ? 3'h2 : 3'h4;
   // second stage: /1 /2 /4, reserved code runs as /1
   assign second_last = (second_sel == 2'h1) ? 2'h1 : (second_sel == 2'h2) ? 2'h3 : 2'h0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         first_count  <= 3'h0;
         second_count <= 2'h0;
         first_tick   <= 1'b0;
         sample_tick  <= 1'b0;
      end else if (hold) begin
         first_count  <= 3'h0;
         second_count <= 2'h0;
         first_tick   <= 1'b0;
         sample_tick  <= 1'b0;
      end else begin
         first_count <= first_wrap ? 3'h0 : first_count + 3'h1;
         first_tick  <= first_wrap;
         // second stage advances only on first-stage output
         if (first_wrap) begin
            second_count <= second_wrap ? 2'h0 : second_count + 2'h1;
         end
         sample_tick <= first_wrap && second_wrap;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sample_in_first_a: assert property (sample_tick |-> first_tick)
      else $error("sample tick without first-stage tick");
   first_div5_a: assert property ((first_tick && first_sel == 2'h0)
      ##1 (!hold && first_sel == 2'h0)[*5] |-> first_tick)
      else $error("first stage not dividing by five");
endmodule

// ---- hw/pwrcfg_pkg.sv ----
package pwrcfg_pkg;
   // register offsets on the serial control port
   localparam logic [7:0] PWRCFG_OFS_POWER_MODE = 8'h37;
   localparam logic [7:0] PWRCFG_OFS_TIMESTAMP  = 8'h3b;
   localparam logic [7:0] PWRCFG_OFS_REFOUT     = 8'h3c;
   localparam logic [7:0] PWRCFG_OFS_FBDIV      = 8'h3d;
   // reset values
   localparam logic [7:0] PWRCFG_RST_POWER_MODE = 8'h4b;
   localparam logic [7:0] PWRCFG_RST_TIMESTAMP  = 8'h00;
   localparam logic [7:0] PWRCFG_RST_REFOUT     = 8'h01;
   localparam logic [7:0] PWRCFG_RST_FBDIV      = 8'h00;
   // power mode codes
   localparam logic [7:0] PWRCFG_MODE_LOW_POWER = 8'h46;
   localparam logic [7:0] PWRCFG_MODE_HIGH_PERF = 8'h4b;
   // field positions
   localparam int PWRCFG_BIT_RECV_EN   = 0;
   localparam int PWRCFG_BIT_PECL      = 1;
   localparam int PWRCFG_BIT_REFOUT_EN = 0;
   localparam int PWRCFG_LSB_FIRST_DIV  = 0;
   localparam int PWRCFG_LSB_SECOND_DIV = 2;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] data;
   } pwrcfg_req_type;
endpackage

// ---- hw/pwrcfg_regs.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - power code 0x46 selects low power, 0x4b high performance; others reserved
// - timestamp bit 0 enables the timestamp receiver, resets to zero
// - timestamp bit 1 selects pecl mode: grounded termination, no self-bias
// - reference output active when refout enable and pll enable both set
// - second divider bits 3:2 give /1 /2 /4, code 3 reserved
// - first divider bits 1:0 give /5 /4 /3, code 3 reserved
// - first divider output feeds second; second produces the sampling clock
module pwrcfg_regs (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire pwrcfg_pkg::pwrcfg_req_type req,
   input  wire logic                       pll_enable,
   input  wire logic                       pll_hold_reset,
   input  wire logic                       calibration_enable,
   input  wire logic                       serial_link_enable,
   output logic [7:0]                      rd_data,
   output logic                            rd_valid,
   output logic                            low_power_mode,
   output logic                            high_perf_mode,
   output logic                            power_mode_reserved,
   output logic                            timestamp_receiver_enable,
   output logic                            timestamp_pecl_mode,
   output logic                            pll_reference_output,
   output logic [2:0]                      first_div_ratio,
   output logic [2:0]                      second_div_ratio,
   output logic                            sample_tick,
   output logic                            mode_order_error,
   output logic                            divider_order_error
);
   import pwrcfg_pkg::*;

   //////////////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] power_mode_select;
   logic [7:0] timestamp_input_control;
   logic [7:0] pll_refout_control;
   logic [7:0] pll_feedback_divider_select;

   wire hit_mode   = (req.addr == PWRCFG_OFS_POWER_MODE);
   wire hit_tstamp = (req.addr == PWRCFG_OFS_TIMESTAMP);
   wire hit_refout = (req.addr == PWRCFG_OFS_REFOUT);
   wire hit_fbdiv  = (req.addr == PWRCFG_OFS_FBDIV);
   wire wr_mode    = req.write && hit_mode;
   wire wr_fbdiv   = req.write && hit_fbdiv;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_mode_select           <= PWRCFG_RST_POWER_MODE;
         timestamp_input_control     <= PWRCFG_RST_TIMESTAMP;
         pll_refout_control          <= PWRCFG_RST_REFOUT;
         pll_feedback_divider_select <= PWRCFG_RST_FBDIV;
      end else if (req.write) begin
         // whole byte stored, reserved bits included
         if (hit_mode)   power_mode_select           <= req.data;
         if (hit_tstamp) timestamp_input_control     <= req.data;
         if (hit_refout) pll_refout_control          <= req.data;
         if (hit_fbdiv)  pll_feedback_divider_select <= req.data;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // read path, unmapped offsets read zero
   wire [7:0] next_rd_data = hit_mode   ? power_mode_select :
                             hit_tstamp ? timestamp_input_control :
                             hit_refout ? pll_refout_control :
                             hit_fbdiv  ? pll_feedback_divider_select : 8'h00;

   //////////////////////////////////////////////////////////////////////////////////////
   // decoded controls
   wire [1:0] first_sel  = pll_feedback_divider_select[PWRCFG_LSB_FIRST_DIV +: 2];
   wire [1:0] second_sel = pll_feedback_divider_select[PWRCFG_LSB_SECOND_DIV +: 2];
   wire [2:0] next_first_ratio  = (first_sel == 2'h1) ? 3'h4 :
                                  (first_sel == 2'h2) ? 3'h3 : 3'h5;
   wire [2:0] next_second_ratio = (second_sel == 2'h1) ? 3'h2 :
                                  (second_sel == 2'h2) ? 3'h4 : 3'h1;
   wire       next_low_power = (power_mode_select == PWRCFG_MODE_LOW_POWER);
   wire       next_high_perf = (power_mode_select == PWRCFG_MODE_HIGH_PERF);
   // host ordering checks, reported but never blocking the write
   wire       next_mode_err  = wr_mode && (calibration_enable || serial_link_enable);
   wire       next_div_err   = wr_fbdiv && !pll_hold_reset
                               && (req.data[3:0] != pll_feedback_divider_select[3:0]);
   wire       divider_hold   = pll_hold_reset || !pll_enable;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data                   <= 8'h00;
         rd_valid                  <= 1'b0;
         low_power_mode            <= 1'b0;
         high_perf_mode            <= 1'b0;
         power_mode_reserved       <= 1'b0;
         timestamp_receiver_enable <= 1'b0;
         timestamp_pecl_mode       <= 1'b0;
         pll_reference_output      <= 1'b0;
         first_div_ratio           <= 3'h5;
         second_div_ratio          <= 3'h1;
         mode_order_error          <= 1'b0;
         divider_order_error       <= 1'b0;
      end else begin
         rd_data                   <= req.read ? next_rd_data : 8'h00;
         rd_valid                  <= req.read;
         low_power_mode            <= next_low_power;
         high_perf_mode            <= next_high_perf;
         power_mode_reserved       <= !next_low_power && !next_high_perf;
         timestamp_receiver_enable <= timestamp_input_control[PWRCFG_BIT_RECV_EN];
         timestamp_pecl_mode       <= timestamp_input_control[PWRCFG_BIT_PECL];
         pll_reference_output      <= pll_refout_control[PWRCFG_BIT_REFOUT_EN]
                                      && pll_enable;
         first_div_ratio           <= next_first_ratio;
         second_div_ratio          <= next_second_ratio;
         mode_order_error          <= next_mode_err;
         divider_order_error       <= next_div_err;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // feedback divider cascade
   pwrcfg_fbdiv u_fbdiv (
      .clk         (clk),
      .reset       (reset),
      .hold        (divider_hold),
      .first_sel   (first_sel),
      .second_sel  (second_sel),
      .first_tick  (),
      .sample_tick (sample_tick)
   );

   //////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence mode_write_s(logic [7:0] code);
      req.write && hit_mode && req.data == code && !req.read;
   endsequence

   mode_low_power_a: assert property (mode_write_s(8'h46) ##1 !wr_mode |=> low_power_mode
      && !high_perf_mode && !power_mode_reserved)
      else $error("low power code not decoded");
   mode_reserved_a: assert property (mode_write_s(8'h00) ##1 !wr_mode |=> power_mode_reserved
      && !low_power_mode)
      else $error("reserved power code not flagged");
   recv_enable_a: assert property (req.write && hit_tstamp ##1 !(req.write && hit_tstamp)
      |=> timestamp_receiver_enable == $past(req.data[0], 2))
      else $error("timestamp receiver enable mismatch");
   pecl_mode_a: assert property (req.write && hit_tstamp ##1 !(req.write && hit_tstamp)
      |=> timestamp_pecl_mode == $past(req.data[1], 2))
      else $error("timestamp pecl mode mismatch");
   refout_follow_a: assert property (!$past(reset) |-> pll_reference_output ==
      ($past(pll_refout_control[0]) && $past(pll_enable)))
      else $error("reference output does not follow enables");
   second_ratio_a: assert property (wr_fbdiv && req.data[3:2] == 2'h2 ##1 !wr_fbdiv
      |=> second_div_ratio == 3'h4)
      else $error("second divider ratio wrong");
   first_ratio_a: assert property (wr_fbdiv && req.data[1:0] == 2'h2 ##1 !wr_fbdiv
      |=> first_div_ratio == 3'h3)
      else $error("first divider ratio wrong");
   cascade_rate_a: assert property ((sample_tick && first_sel == 2'h1 && second_sel == 2'h1)
      ##1 (!divider_hold && !wr_fbdiv)[*8] |-> sample_tick)
      else $error("cascade period not eight cycles");
   readback_a: assert property (req.write && hit_refout ##1 (req.read && hit_refout
      && !req.write) |=> rd_valid && rd_data == $past(req.data, 2))
      else $error("register readback mismatch");
   mode_order_a: assert property (wr_mode && calibration_enable |=> mode_order_error)
      else $error("mode write with calibration enabled not flagged");
endmodule

// ---- tb/pwrcfg_host.sv ----
`timescale 1ns/1ps
module pwrcfg_host (
   input  wire logic                  clk,
   input  wire logic [7:0]            rd_data,
   input  wire logic                  rd_valid,
   output pwrcfg_pkg::pwrcfg_req_type req,
   output logic                       cal_en,
   output logic                       link_en,
   output logic                       hold,
   output logic                       pll_en
);
   import pwrcfg_pkg::*;
   initial begin
      req = '0;
      cal_en = 1'b0;
      link_en = 1'b0;
      hold = 1'b1;
      pll_en = 1'b1;
   end
   // a careless host skips the quieting steps
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit polite);
      if (polite && a == PWRCFG_OFS_POWER_MODE) begin
         cal_en = 1'b0;
         link_en = 1'b0;
      end
      if (polite && a == PWRCFG_OFS_FBDIV) hold = 1'b1;
      @(posedge clk);
      #1 req = '{write: 1'b1, read: 1'b0, addr: a, data: d};
      @(posedge clk);
      #1 req = '0;
      if (a == PWRCFG_OFS_POWER_MODE) cal_en = 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      #1 req = '{write: 1'b0, read: 1'b1, addr: a, data: 8'h00};
      @(posedge clk);
      #1 req = '0;
      d = rd_data;
      v = rd_valid;
   endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import pwrcfg_pkg::*;
   logic           clk, reset, cal_en, link_en, hold, pll_en, rd_valid, v, me, de;
   logic           low_p, high_p, rsv, ts_en, ts_pecl, refout, tick, m_err, d_err;
   pwrcfg_req_type req;
   logic [7:0]     rd_data, d, x, a;
   logic [2:0]     r1, r2;
   logic [1:0]     c1, c2;
   logic [7:0]     mdl [logic [7:0]];
   logic [7:0]     offs [5] = '{8'h37, 8'h3b, 8'h3c, 8'h3d, 8'h38};
   int             err_count = 0;
   int             compares = 0;
   int             seed = 32'hccb2bf35;
   int             n, e;
   pwrcfg_regs pwrcfg_regs_i (.clk(clk), .reset(reset), .req(req), .pll_enable(pll_en),
      .pll_hold_reset(hold), .calibration_enable(cal_en), .serial_link_enable(link_en),
      .rd_data(rd_data), .rd_valid(rd_valid), .low_power_mode(low_p), .high_perf_mode(high_p),
      .power_mode_reserved(rsv), .timestamp_receiver_enable(ts_en),
      .timestamp_pecl_mode(ts_pecl), .pll_reference_output(refout), .first_div_ratio(r1),
      .second_div_ratio(r2), .sample_tick(tick), .mode_order_error(m_err),
      .divider_order_error(d_err));
   pwrcfg_host pwrcfg_host_i (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req),
      .cal_en(cal_en), .link_en(link_en), .hold(hold), .pll_en(pll_en));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic init_mdl();
      mdl[PWRCFG_OFS_POWER_MODE] = PWRCFG_RST_POWER_MODE;
      mdl[PWRCFG_OFS_TIMESTAMP] = PWRCFG_RST_TIMESTAMP;
      mdl[PWRCFG_OFS_REFOUT] = PWRCFG_RST_REFOUT;
      mdl[PWRCFG_OFS_FBDIV] = PWRCFG_RST_FBDIV;
   endtask
   // gathers error pulses, returns with decoded outputs settled
   task automatic wr(input logic [7:0] ad, input logic [7:0] dd, input bit polite);
      pwrcfg_host_i.wr(ad, dd, polite);
      if (mdl.exists(ad)) mdl[ad] = dd;
      me = m_err;
      de = d_err;
      repeat (2) begin
         @(posedge clk);
         #1 me |= m_err;
         de |= d_err;
      end
   endtask
   task automatic rdchk(input logic [7:0] ad);
      pwrcfg_host_i.rd(ad, d, v);
      chk(8'(v), 8'h01);
      chk(d, mdl.exists(ad) ? mdl[ad] : 8'h00);
   endtask
   task automatic measure(output int cnt);
      int k;
      cnt = 0;
      for (k = 0; k < 100 && tick !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      if (tick !== 1'b1) begin
         err_count++;
         report_and_stop();
      end
      do begin
         @(posedge clk);
         #1 cnt++;
      end while (tick !== 1'b1 && cnt < 100);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      init_mdl();
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      foreach (mdl[k]) rdchk(k);
      chk(8'({high_p, low_p, rsv, refout, ts_en, ts_pecl}), 8'h24);
      chk(8'({r1, r2}), 8'({3'd5, 3'd1}));
      for (int i = 0; i < 4; i++) begin
         x = i == 0 ? PWRCFG_MODE_LOW_POWER : i == 1 ? PWRCFG_MODE_HIGH_PERF :
             i == 2 ? 8'h00 : 8'($random(seed));
         wr(PWRCFG_OFS_POWER_MODE, x, 1'b1);
         chk(8'({low_p, high_p, rsv, me}), 8'({x == 8'h46, x == 8'h4b,
            x != 8'h46 && x != 8'h4b, 1'b0}));
         rdchk(PWRCFG_OFS_POWER_MODE);
      end
      wr(PWRCFG_OFS_POWER_MODE, PWRCFG_MODE_HIGH_PERF, 1'b0);
      chk(8'(me), 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(PWRCFG_OFS_TIMESTAMP, 8'(i), 1'b1);
         chk(8'({ts_pecl, ts_en}), 8'(i));
         pwrcfg_host_i.pll_en = i[1];
         wr(PWRCFG_OFS_REFOUT, {7'h0, i[0]}, 1'b1);
         chk(8'(refout), 8'(i[0] & i[1]));
      end
      for (int i = 0; i < 9; i++) begin
         c1 = 2'(i % 3);
         c2 = 2'(i / 3);
         wr(PWRCFG_OFS_FBDIV, {4'h0, c2, c1}, 1'b1);
         chk(8'({de, r1, r2}), 8'({1'b0, 3'(c1 == 0 ? 5 : c1 == 1 ? 4 : 3),
            3'(c2 == 0 ? 1 : c2 == 1 ? 2 : 4)}));
         e = (c1 == 0 ? 5 : c1 == 1 ? 4 : 3) * (c2 == 0 ? 1 : c2 == 1 ? 2 : 4);
         pwrcfg_host_i.hold = 1'b0;
         measure(n);
         chk(8'(n), 8'(e));
      end
      wr(PWRCFG_OFS_FBDIV, 8'h05, 1'b0);
      chk(8'(de), 8'h01);
      wr(PWRCFG_OFS_FBDIV, 8'h05, 1'b0);
      chk(8'(de), 8'h00);
      for (int i = 0; i < 8; i++) begin
         a = offs[$unsigned($random(seed)) % 5];
         wr(a, 8'($random(seed)), 1'b1);
         rdchk(a);
      end
      reset = 1'b1;
      @(posedge clk);
      #1 reset = 1'b0;
      init_mdl();
      foreach (mdl[k]) rdchk(k);
      report_and_stop();
   end
endmodule
